// File: design/nand_host.sv
`timescale 1ns/1ps
`include "nand_host_defines.svh"

module nand_host
	import nand_host_pkg::*;
#(
	parameter int STROBE_CYCLES = `STROBE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic ce_n,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic read_strobe_n,
	output logic wp_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic ready_busy_out
);

	localparam int PULSE_RD = STROBE_CYCLES + `SYNC_EXTRA;

	if (STROBE_CYCLES < 1 || PULSE_RD > 15) begin : g_bad_strobe
		$error("STROBE_CYCLES out of range");
	end

	state_t state;
	op_t op, req_op;
	logic [2:0] step, rd_idx, req_raw;
	logic [3:0] cnt;
	logic [7:0] io_s1, io_s2, stat_byte, last_cmd, step_byte;
	logic [7:0] id_mem [0:`ID_BYTES-1];
	step_kind_t kind;
	logic rb_s1, rb_s2, smode, refused, wp_reg;
	logic wr_en, rd_en, ctrl_wr, start_ok, mapped;

	// two flops on everything coming off the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_s1 <= 8'h00;
			io_s2 <= 8'h00;
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
		end else begin
			io_s1 <= io_in;
			io_s2 <= io_s1;
			rb_s1 <= ready_busy_out;
			rb_s2 <= rb_s1;
		end
	end

	// step table per operation; only fixed codes can reach the pins
	always_comb begin
		kind = STEP_END;
		step_byte = 8'h00;
		unique case (op)
			OP_ID: begin
				if (step == 3'd0) begin
					kind = STEP_CMD;
					step_byte = `CMD_ID;
				end else if (step == 3'd1) begin
					kind = STEP_ADDR;
					step_byte = `ADDR_ID;
				end else if (step < 3'(2 + `ID_BYTES)) begin
					kind = STEP_READ;
				end
			end
			OP_STATUS, OP_DIST: begin
				if (step == 3'd0) begin
					kind = STEP_CMD;
					step_byte = (op == OP_DIST) ? `CMD_DIST : `CMD_STATUS;
				end else if (step == 3'd1) begin
					kind = STEP_READ;
				end
			end
			OP_RESET, OP_RESUME: begin
				if (step == 3'd0) begin
					kind = STEP_CMD;
					step_byte = (op == OP_RESET) ? `CMD_RESET : `CMD_READ;
				end
			end
			OP_POLL: kind = (step == 3'd0) ? STEP_READ : STEP_END;
			default: kind = STEP_END;
		endcase
	end

	// apb decode; zero wait states, so the answer comes in the access cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign mapped = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
		(paddr == `REG_ID_LO) || (paddr == `REG_ID_HI);
	assign pslverr = psel && penable && !mapped;
	assign ctrl_wr = wr_en && (paddr == `REG_CTRL);
	assign req_raw = pwdata[`CTRL_OP_LSB +: 3];
	assign req_op = op_t'(req_raw);

	// busy device (also power-up init) takes only the two status reads, reset and, in status mode, poll;
	// poll and resume only make sense inside status mode
	always_comb begin
		start_ok = 1'b0;
		if (state == S_IDLE) begin
			unique case (req_raw)
				3'(OP_STATUS), 3'(OP_DIST), 3'(OP_RESET): start_ok = 1'b1;
				3'(OP_ID): start_ok = rb_s2;
				3'(OP_RESUME): start_ok = smode && rb_s2;
				3'(OP_POLL): start_ok = smode;
				default: start_ok = 1'b0;
			endcase
		end
	end

	// write protect level, software owned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_reg <= 1'b0;
		end else if (ctrl_wr) begin
			wp_reg <= pwdata[`CTRL_WP_BIT];
		end
	end

	// refused request flag; write one to clear, a new refusal wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refused <= 1'b0;
		end else if (ctrl_wr && !start_ok) begin
			refused <= 1'b1;
		end else if (wr_en && (paddr == `REG_STATUS) && pwdata[`ST_REFUSED_BIT]) begin
			refused <= 1'b0;
		end
	end

	// sequencer across command, address and read cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			op <= OP_STATUS;
			step <= 3'd0;
			cnt <= 4'd0;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (ctrl_wr && start_ok) begin
						op <= req_op;
						step <= 3'd0;
						state <= S_SETUP;
					end
				end
				S_SETUP: begin
					cnt <= (kind == STEP_READ) ? 4'(PULSE_RD) : 4'(STROBE_CYCLES);
					state <= S_PULSE;
				end
				S_PULSE: begin
					if (cnt == 4'd1) begin
						state <= S_HOLD;
					end
					cnt <= cnt - 4'd1;
				end
				S_HOLD: begin
					step <= step + 3'd1;
					state <= S_DONE;
				end
				S_DONE: begin
					state <= (kind == STEP_END) ? S_IDLE : S_SETUP;
				end
			endcase
		end
	end

	// pin drive, all from flops; cle/ale/data held through the hold cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ce_n <= 1'b1;
			cle <= 1'b0;
			ale <= 1'b0;
			we_n <= 1'b1;
			read_strobe_n <= 1'b1;
			io_out <= 8'h00;
			io_oe <= 1'b0;
			wp_n <= 1'b0;
		end else begin
			wp_n <= wp_reg;
			unique case (state)
				S_IDLE: begin
					ce_n <= !(ctrl_wr && start_ok);
					cle <= 1'b0;
					ale <= 1'b0;
					io_oe <= 1'b0;
				end
				S_SETUP: begin
					cle <= (kind == STEP_CMD);
					ale <= (kind == STEP_ADDR);
					io_out <= step_byte;
					io_oe <= (kind != STEP_READ);
					we_n <= (kind == STEP_READ);
					read_strobe_n <= (kind != STEP_READ);
				end
				S_PULSE: begin
					if (cnt == 4'd1) begin
						we_n <= 1'b1;
						read_strobe_n <= 1'b1;
					end
				end
				S_HOLD: begin
					cle <= 1'b0;
					ale <= 1'b0;
					io_oe <= 1'b0;
				end
				S_DONE: begin
					ce_n <= (kind == STEP_END);
				end
			endcase
		end
	end

	// read capture: synced data is settled by the last low cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_idx <= 3'd0;
			stat_byte <= 8'h00;
		end else if (state == S_IDLE && ctrl_wr && start_ok) begin
			rd_idx <= 3'd0;
		end else if (state == S_PULSE && cnt == 4'd1 && kind == STEP_READ) begin
			if (op == OP_ID) begin
				rd_idx <= rd_idx + 3'd1;
			end else begin
				stat_byte <= io_s2;
			end
		end
	end

	// id byte store, one slot per byte
	genvar gi;
	generate
		for (gi = 0; gi < `ID_BYTES; gi++) begin : g_id
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					id_mem[gi] <= 8'h00;
				end else if (state == S_PULSE && cnt == 4'd1 && kind == STEP_READ &&
					op == OP_ID && rd_idx == 3'(gi)) begin
					id_mem[gi] <= io_s2;
				end
			end
		end
	endgenerate

	// command history: status mode entry and exit, last command sent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smode <= 1'b0;
			last_cmd <= `CMD_RESET;
		end else if (state == S_HOLD && (kind == STEP_CMD)) begin
			last_cmd <= step_byte;
			smode <= (step_byte == `CMD_STATUS) || (step_byte == `CMD_DIST);
		end
	end

	// status interpretation; fail bits only count with ready shown
	logic cur_fail, prev_fail, mismatch;
	assign cur_fail = stat_byte[`SB_FAIL_CUR] && stat_byte[`SB_PAGE_RDY];
	assign prev_fail = stat_byte[`SB_FAIL_PREV] && stat_byte[`SB_CACHE_RDY];
	// no cache command is ever sent here, so a split is an anomaly
	assign mismatch = (stat_byte[`SB_PAGE_RDY] != stat_byte[`SB_CACHE_RDY]) &&
		(last_cmd != `CMD_CACHE_PROG) && (last_cmd != `CMD_CACHE_READ);

	// read mux
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			unique case (paddr)
				`REG_CTRL: begin
					prdata[`CTRL_WP_BIT] = wp_reg;
					prdata[`CTRL_OP_LSB +: 3] = op;
				end
				`REG_STATUS: begin
					prdata[`ST_ACTIVE_BIT] = (state != S_IDLE);
					prdata[`ST_RB_BIT] = rb_s2;
					prdata[`ST_REFUSED_BIT] = refused;
					prdata[`ST_SMODE_BIT] = smode;
					prdata[`ST_BYTE_LSB +: 8] = stat_byte;
					prdata[`ST_CUR_FAIL_BIT] = cur_fail;
					prdata[`ST_PREV_FAIL_BIT] = prev_fail;
					prdata[`ST_UNPROT_BIT] = stat_byte[`SB_UNPROT];
					prdata[`ST_PAGE_RDY_BIT] = stat_byte[`SB_PAGE_RDY];
					prdata[`ST_CACHE_RDY_BIT] = stat_byte[`SB_CACHE_RDY];
					prdata[`ST_MISMATCH_BIT] = mismatch;
				end
				`REG_ID_LO: prdata = {id_mem[3], id_mem[2], id_mem[1], id_mem[0]};
				`REG_ID_HI: begin
					prdata[7:0] = id_mem[4];
					prdata[9:8] = id_mem[2][`ID_CHIPS_LSB +: 2];
					prdata[11:10] = id_mem[2][`ID_CELL_LSB +: 2];
					prdata[13:12] = id_mem[3][`ID_PAGE_LSB +: 2];
					prdata[15:14] = id_mem[3][`ID_BLOCK_LSB +: 2];
					prdata[16] = id_mem[3][`ID_WIDTH_BIT];
					prdata[18:17] = id_mem[4][`ID_DIST_LSB +: 2];
				end
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

endmodule

// File: shared/nand_host_defines.svh
`ifndef NAND_HOST_DEFINES_SVH
`define NAND_HOST_DEFINES_SVH

// register byte offsets on the apb side
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_ID_LO 12'h008
`define REG_ID_HI 12'h00c

// control register fields
`define CTRL_OP_LSB 0
`define CTRL_WP_BIT 8
`define CTRL_RESET 32'h0000_0000

// status register fields
`define ST_ACTIVE_BIT 0
`define ST_RB_BIT 1
`define ST_REFUSED_BIT 2
`define ST_SMODE_BIT 3
`define ST_BYTE_LSB 8
`define ST_CUR_FAIL_BIT 16
`define ST_PREV_FAIL_BIT 17
`define ST_UNPROT_BIT 18
`define ST_PAGE_RDY_BIT 19
`define ST_CACHE_RDY_BIT 20
`define ST_MISMATCH_BIT 21

// status byte bit positions on the i/o port
`define SB_FAIL_CUR 0
`define SB_FAIL_PREV 1
`define SB_PAGE_RDY 5
`define SB_CACHE_RDY 6
`define SB_UNPROT 7

// id byte field positions
`define ID_CHIPS_LSB 0
`define ID_CELL_LSB 2
`define ID_PAGE_LSB 0
`define ID_BLOCK_LSB 4
`define ID_WIDTH_BIT 6
`define ID_DIST_LSB 2

// command codes the controller may send, plus cache codes it only checks status against
`define CMD_READ 8'h00
`define CMD_ID 8'h90
`define CMD_STATUS 8'h70
`define CMD_DIST 8'h71
`define CMD_RESET 8'hff
`define CMD_CACHE_PROG 8'h15
`define CMD_CACHE_READ 8'h31
`define ADDR_ID 8'h00
`define ID_BYTES 5

// strobe timing
`define T_CLK_NS 10
`define T_STROBE_NS 25
`define STROBE_CYCLES ((`T_STROBE_NS + `T_CLK_NS - 1) / `T_CLK_NS)
`define SYNC_EXTRA 2

`endif

// File: shared/nand_host_pkg.sv
package nand_host_pkg;

	typedef enum logic [2:0] {
		OP_ID = 3'h0,
		OP_STATUS = 3'h1,
		OP_DIST = 3'h2,
		OP_RESET = 3'h3,
		OP_RESUME = 3'h4,
		OP_POLL = 3'h5
	} op_t;

	typedef enum logic [1:0] {
		STEP_CMD = 2'h0,
		STEP_ADDR = 2'h1,
		STEP_READ = 2'h2,
		STEP_END = 2'h3
	} step_kind_t;

	// gray codes along idle-setup-pulse-hold-done
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SETUP = 3'b001,
		S_PULSE = 3'b011,
		S_HOLD = 3'b010,
		S_DONE = 3'b110
	} state_t;

endpackage

// File: testbench/nand_dev_model.sv
`timescale 1ns/1ps
module nand_dev_model #(
	parameter logic [7:0] MAKER = 8'h5a,
	parameter logic [7:0] DEVICE = 8'h3c
) (
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic read_strobe_n,
	input wire logic wp_n,
	input wire logic [7:0] io_out,
	input wire logic busy_req,
	input wire logic cur_fail,
	input wire logic prev_fail,
	output logic [7:0] dq,
	output logic rb_low
);
	logic [7:0] cmd;
	logic [2:0] idx;
	logic abort;
	initial begin
		cmd = 8'h00;
		idx = 3'h0;
		abort = 1'b0;
		dq = 8'h00;
	end
	// busy from power-up or a job until a reset command aborts it
	assign rb_low = busy_req & !abort;
	always @(posedge busy_req) abort <= 1'b0;
	// commands and the id address latch on the rising write strobe
	always @(posedge we_n) if (!ce_n) begin
		if (cle) cmd <= io_out;
		if (cle && io_out == 8'hff) abort <= 1'b1;
		if (ale) idx <= 3'h0;
	end
	// live byte on each falling read strobe; no cache ops so bits 5 and 6 agree
	always @(negedge read_strobe_n) if (!ce_n) begin
		if (cmd == 8'h90) begin
			dq <= idx == 0 ? MAKER : idx == 1 ? DEVICE : idx == 2 ? 8'h90 :
				idx == 3 ? 8'h26 : 8'h76;
			idx <= idx + 3'h1;
		end else if (cmd == 8'h70 || cmd == 8'h71) begin
			dq <= {wp_n, !rb_low, !rb_low, 3'h0, cmd[0] ? cur_fail : prev_fail, cur_fail};
		end else dq <= ~dq;
	end
	// released bus shows no stale byte
	always @(posedge read_strobe_n) dq <= ~dq;
endmodule

// File: testbench/nand_host_sva.sv
`timescale 1ns/1ps
module nand_host_sva #(
	parameter int STROBE_CYCLES = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	input wire logic ready_busy_out
);
	logic [7:0] wlo;
	logic [7:0] rlo;
	logic [7:0] blo;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// low-time counters; busy count saturates so long spells never wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wlo <= 8'h00;
			rlo <= 8'h00;
			blo <= 8'h00;
		end else begin
			wlo <= we_n ? 8'h00 : wlo + 8'h01;
			rlo <= read_strobe_n ? 8'h00 : rlo + 8'h01;
			blo <= ready_busy_out ? 8'h00 : ((blo == 8'hff) ? blo : blo + 8'h01);
		end
	end
	property p_excl; !(!we_n && !read_strobe_n); endproperty
	a_excl: assert property (p_excl) else $error("both strobes low");
	property p_we_len; $rose(we_n) |-> wlo == 8'(STROBE_CYCLES); endproperty
	a_we_len: assert property (p_we_len) else $error("write strobe length");
	property p_re_len; $rose(read_strobe_n) |-> rlo == 8'(STROBE_CYCLES + 2); endproperty
	a_re_len: assert property (p_re_len) else $error("read strobe length");
	property p_no_fight; !read_strobe_n |-> !io_oe; endproperty
	a_no_fight: assert property (p_no_fight) else $error("driving during read");
	property p_known; cle && !we_n |-> io_out inside {8'h00, 8'h90, 8'h70, 8'h71, 8'hff};
	endproperty
	a_known: assert property (p_known) else $error("undefined command");
	property p_hold; !we_n && !$fell(we_n) |-> $stable(io_out) && io_oe; endproperty
	a_hold: assert property (p_hold) else $error("io moved under strobe");
	property p_addr; ale && !we_n |-> !cle && io_out == 8'h00; endproperty
	a_addr: assert property (p_addr) else $error("bad id address");
	property p_busy; cle && !we_n && blo > 8'h06 |-> io_out inside {8'h70, 8'h71, 8'hff};
	endproperty
	a_busy: assert property (p_busy) else $error("command while busy");
	property p_idle; ce_n |-> we_n && read_strobe_n && !cle && !ale; endproperty
	a_idle: assert property (p_idle) else $error("strobes while deselected");
	property p_unmap; psel && penable && paddr > 12'h00c |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped not flagged");
	property p_quiet; !(psel && penable) |-> prdata == 32'h0 && !pslverr; endproperty
	a_quiet: assert property (p_quiet) else $error("read data outside access");
endmodule

// File: testbench/tb_nand_host.sv
`timescale 1ns/1ps
module tb_nand_host;
	localparam int STROBE_CYCLES = 3;
	localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
	localparam logic [7:0] DEVICE = 8'h3c; // arbitrary value
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe, rb_low, busy_req, cur, prev;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] io_out, dq;
	int miscompares, checks, i;
	wire ready_busy_out = !rb_low; // pull-up, only the device pulls low
	wire [7:0] io_in = io_oe ? io_out : dq;
	nand_host #(.STROBE_CYCLES(STROBE_CYCLES)) nand_host_inst (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ce_n, .cle, .ale,
		.we_n, .read_strobe_n, .wp_n, .io_in, .io_out, .io_oe, .ready_busy_out);
	nand_dev_model #(.MAKER(MAKER), .DEVICE(DEVICE)) nand_dev_model_inst (.ce_n, .cle, .ale,
		.we_n, .read_strobe_n, .wp_n, .io_out, .busy_req, .cur_fail(cur), .prev_fail(prev),
		.dq, .rb_low);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task close_out;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; setup always starts a fresh edge after release
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin miscompares++; close_out; end
	endtask
	// start an operation and poll until the sequencer is idle
	task op(input logic [2:0] c, input logic wp);
		int n;
		xfer(1'b1, 12'h000, {23'h0, wp, 5'h0, c});
		n = 0;
		do begin xfer(1'b0, 12'h004, 32'h0); n++; end while (rd[0] !== 1'b0 && n < 60);
		if (n >= 60) begin miscompares++; close_out; end
		xfer(1'b0, 12'h004, 32'h0);
	endtask
	function automatic logic [31:0] st(logic [7:0] sb, logic rb, logic rf, logic sm);
		return {10'h0, sb[5] ^ sb[6], sb[6], sb[5], sb[7], sb[1] & sb[6], sb[0] & sb[5],
			sb, 4'h0, sm, rf, rb, 1'b0};
	endfunction
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		close_out;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, cur, prev} = '0;
		busy_req = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// power-up busy: id refused, status allowed
		op(3'h0, 1'b0); chk(rd & 32'h6, 32'h4);
		xfer(1'b1, 12'h004, 32'h4);
		op(3'h1, 1'b0); chk(rd, st(8'h00, 1'b0, 1'b0, 1'b1));
		op(3'h3, 1'b0);
		repeat (4) @(posedge pclk);
		op(3'h1, 1'b0); chk(rd, st(8'h60, 1'b1, 1'b0, 1'b1));
		busy_req <= 1'b0;
		// pass/fail, protect and both status commands
		for (i = 0; i < 3; i++) begin
			cur <= i != 1;
			prev <= i != 0;
			op(i == 2 ? 3'h2 : 3'h1, i != 2);
			chk(rd, st({i != 2, 5'h18, i != 0, i != 1}, 1'b1, 1'b0, 1'b1));
		end
		busy_req <= 1'b1;
		repeat (4) @(posedge pclk);
		op(3'h5, 1'b0); chk(rd, st(8'h03, 1'b0, 1'b0, 1'b1));
		op(3'h4, 1'b0); chk(rd & 32'he, 32'hc);
		xfer(1'b1, 12'h004, 32'h4);
		op(3'h0, 1'b0); chk(rd & 32'h6, 32'h4);
		xfer(1'b1, 12'h004, 32'h4);
		busy_req <= 1'b0;
		repeat (4) @(posedge pclk);
		op(3'h4, 1'b0);
		op(3'h5, 1'b0); chk(rd & 32'he, 32'h6);
		xfer(1'b1, 12'h004, 32'h4);
		op(3'h0, 1'b0);
		xfer(1'b0, 12'h008, 32'h0); chk(rd, {8'h26, 8'h90, DEVICE, MAKER});
		xfer(1'b0, 12'h00c, 32'h0); chk(rd, 32'h0002a076);
		xfer(1'b0, 12'h010, 32'h0); chk({rd[30:0], er}, 32'h1);
		close_out;
	end
endmodule
bind nand_host nand_host_sva #(.STROBE_CYCLES(STROBE_CYCLES)) sva_inst (.pclk, .presetn, .psel,
	.penable, .paddr, .prdata, .pslverr, .ce_n, .cle, .ale, .we_n, .read_strobe_n, .io_out,
	.io_oe, .ready_busy_out);
